//--- design/cpw_pkg.sv
// Constants for the capture/compare/PWM channel: register map, field
// positions, mode codes, reset values and divider counts.
// Assumes a 32-bit APB slave with byte addresses in the low 8 bits.
package cpw_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_VAL_LO  = 8'h04;
  localparam logic [7:0] ADDR_VAL_HI  = 8'h08;
  localparam logic [7:0] ADDR_TB_LO   = 8'h0c;
  localparam logic [7:0] ADDR_TB_HI   = 8'h10;
  localparam logic [7:0] ADDR_TB_CTRL = 8'h14;
  localparam logic [7:0] ADDR_PERIOD  = 8'h18;
  localparam logic [7:0] ADDR_PT_CTRL = 8'h1c;
  localparam logic [7:0] ADDR_PT_CNT  = 8'h20;
  localparam logic [7:0] ADDR_FLAGS   = 8'h24;

  // ==========================================================
  // Field positions
  localparam int CTRL_DUTY_LSB = 4;
  localparam int TB_ON_BIT     = 0;
  localparam int TB_EXT_BIT    = 1;
  localparam int PT_PS_LSB     = 0;
  localparam int PT_ON_BIT     = 2;
  localparam int FLAG_EVT_BIT  = 0;
  localparam int FLAG_OVF_BIT  = 1;

  // ==========================================================
  // Channel mode field codes; 11xx is PWM
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_TOGGLE   = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4    = 4'h6;
  localparam logic [3:0] MODE_CAP_16   = 4'h7;
  localparam logic [3:0] MODE_SET      = 4'h8;
  localparam logic [3:0] MODE_CLR      = 4'h9;
  localparam logic [3:0] MODE_SWINT    = 4'ha;
  localparam logic [3:0] MODE_SEV      = 4'hb;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] RST_PERIOD   = 8'hff;
  localparam logic [1:0] INSTR_TOP    = 2'h3;
  localparam logic [3:0] CAP4_TOP     = 4'h3;
  localparam logic [3:0] CAP16_TOP    = 4'hf;
  localparam logic [7:0] PS1_TOP      = 8'h03;
  localparam logic [7:0] PS4_TOP      = 8'h0f;
  localparam logic [7:0] PS16_TOP     = 8'h3f;
  localparam logic [7:0] PS64_TOP     = 8'hff;
endpackage : cpw_pkg

//--- design/cpw_channel.sv
// Capture/compare/PWM channel with its 16-bit time base and 8-bit
// period timer, reached as an APB slave.
// Assumes sleep_i and adc_enable_i come from logic on clk_i; the pin
// and the external time base clock are asynchronous.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
module cpw_channel (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // System
  input  wire logic        sleep_i,
  input  wire logic        adc_enable_i,
  input  wire logic        tb_ext_clk_i,
  // Channel pin
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe_n_o,
  // Special event
  output logic             trigger_o,
  output logic             adc_start_o
);
  // ==========================================================
  // Registers
  logic [3:0]  mode_r;
  logic [1:0]  dlb_r;
  logic [7:0]  val_lo_r, val_hi_r;
  logic [7:0]  val_lo_nxt, val_hi_nxt;
  logic [15:0] tb_r, tb_nxt;
  logic        tb_wrap;
  logic        tb_on_r, tb_ext_r;
  logic [7:0]  period_r, pt_r, ps_r, ps_top;
  logic        pt_on_r;
  logic [1:0]  pt_ps_r, low2, lat2_r;
  logic        evt_flag_r, ovf_flag_r;
  logic [1:0]  div_r;
  logic [1:0]  s1_r, s2_r, s3_r, lvl_r;
  logic [3:0]  pscnt_r;
  logic        match_r, sev_pend_r, out_r;
  logic        pready_r, pslverr_r, trig_r, adc_r, oe_n_r;
  logic [31:0] prdata_r, rd_mux;
  logic        rd_hit;

  // ==========================================================
  // APB decode; one wait state, effects at the pready edge
  logic acc, wr;
  assign acc = psel_i & penable_i & pready_r;
  assign wr  = acc & pwrite_i;

  logic w_ctrl, w_lo, w_hi, w_tlo, w_thi, w_tctl, w_per, w_pctl, w_pcnt, w_flg;
  assign w_ctrl = wr & (paddr_i == cpw_pkg::ADDR_CTRL);
  assign w_lo   = wr & (paddr_i == cpw_pkg::ADDR_VAL_LO);
  assign w_hi   = wr & (paddr_i == cpw_pkg::ADDR_VAL_HI);
  assign w_tlo  = wr & (paddr_i == cpw_pkg::ADDR_TB_LO);
  assign w_thi  = wr & (paddr_i == cpw_pkg::ADDR_TB_HI);
  assign w_tctl = wr & (paddr_i == cpw_pkg::ADDR_TB_CTRL);
  assign w_per  = wr & (paddr_i == cpw_pkg::ADDR_PERIOD);
  assign w_pctl = wr & (paddr_i == cpw_pkg::ADDR_PT_CTRL);
  assign w_pcnt = wr & (paddr_i == cpw_pkg::ADDR_PT_CNT);
  assign w_flg  = wr & (paddr_i == cpw_pkg::ADDR_FLAGS);

  logic ctrl_zero;
  assign ctrl_zero = w_ctrl & (pwdata_i[5:0] == 6'h00);

  // ==========================================================
  // Mode decode
  logic is_pwm, is_cap, is_sev, is_cmp;
  assign is_pwm = (mode_r[3:2] == 2'b11);
  assign is_cap = (mode_r[3:2] == 2'b01);
  assign is_sev = (mode_r == cpw_pkg::MODE_SEV);
  assign is_cmp = (mode_r == cpw_pkg::MODE_TOGGLE) | (mode_r == cpw_pkg::MODE_SET) |
                  (mode_r == cpw_pkg::MODE_CLR) | (mode_r == cpw_pkg::MODE_SWINT) | is_sev;

  // ==========================================================
  // Input synchronisers; a change counts once stages 2 and 3 agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r  <= 2'h0;
      s2_r  <= 2'h0;
      s3_r  <= 2'h0;
      lvl_r <= 2'h0;
    end else begin
      s1_r  <= {tb_ext_clk_i, pin_i};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end
  end

  logic ext_rise, pin_rise, pin_fall;
  assign ext_rise = s2_r[1] & s3_r[1] & ~lvl_r[1];
  assign pin_rise = s2_r[0] & s3_r[0] & ~lvl_r[0];
  assign pin_fall = ~s2_r[0] & ~s3_r[0] & lvl_r[0];

  // ==========================================================
  // Time base tick
  always_ff @(posedge clk_i) begin
    if (rst_i) div_r <= 2'h0;
    else if (!sleep_i) div_r <= div_r + 2'h1;
  end

  logic tb_tick;
  // Internal source stalls in sleep, external keeps running
  assign tb_tick = tb_on_r & (tb_ext_r ? ext_rise : (~sleep_i & (div_r == cpw_pkg::INSTR_TOP)));

  // ==========================================================
  // Capture
  logic [3:0] cap_top;
  logic       cap_ev;
  assign cap_top = (mode_r == cpw_pkg::MODE_CAP_4) ? cpw_pkg::CAP4_TOP : cpw_pkg::CAP16_TOP;

  always_ff @(posedge clk_i) begin
    if (rst_i) pscnt_r <= 4'h0;
    else if (!is_cap) pscnt_r <= 4'h0;
    else if (pin_rise && mode_r[1]) pscnt_r <= (pscnt_r == cap_top) ? 4'h0 : pscnt_r + 4'h1;
  end

  always_comb begin
    unique case (mode_r)
      cpw_pkg::MODE_CAP_FALL: cap_ev = pin_fall;
      cpw_pkg::MODE_CAP_RISE: cap_ev = pin_rise;
      cpw_pkg::MODE_CAP_4,
      cpw_pkg::MODE_CAP_16:   cap_ev = pin_rise & (pscnt_r == cap_top);
      default:                cap_ev = 1'b0;
    endcase
  end

  // ==========================================================
  // Period timer with prescaler; low bits extend it to 10 bits
  logic [7:0] ps_inc;
  logic [1:0] low2_nxt;
  assign ps_inc = ps_r + 8'h01;

  always_comb begin
    unique case (pt_ps_r)
      2'h0: begin ps_top = cpw_pkg::PS1_TOP;  low2 = ps_r[1:0]; low2_nxt = ps_inc[1:0]; end
      2'h1: begin ps_top = cpw_pkg::PS4_TOP;  low2 = ps_r[3:2]; low2_nxt = ps_inc[3:2]; end
      2'h2: begin ps_top = cpw_pkg::PS16_TOP; low2 = ps_r[5:4]; low2_nxt = ps_inc[5:4]; end
      2'h3: begin ps_top = cpw_pkg::PS64_TOP; low2 = ps_r[7:6]; low2_nxt = ps_inc[7:6]; end
    endcase
  end

  logic pt_tick, pt_reload;
  assign pt_tick   = pt_on_r & ~sleep_i & (ps_r == ps_top);
  assign pt_reload = pt_tick & (pt_r == period_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) ps_r <= 8'h00;
    else if (!pt_on_r || pt_tick) ps_r <= 8'h00;
    else if (!sleep_i) ps_r <= ps_r + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) pt_r <= 8'h00;
    else if (w_pcnt) pt_r <= pwdata_i[7:0];
    else if (pt_reload) pt_r <= 8'h00;
    else if (pt_tick) pt_r <= pt_r + 8'h01;
  end

  // Looking one step ahead makes the pin fall as the base reaches the duty,
  // so the high time is exactly the duty count, not one step longer
  logic [9:0] base_nxt;
  assign base_nxt = pt_tick ? {pt_r + 8'h01, 2'h0} : {pt_r, low2_nxt};

  // ==========================================================
  // Next values of time base and value pair
  always_comb begin
    tb_nxt  = tb_r;
    tb_wrap = 1'b0;
    if (tb_tick) begin
      // Reset only if the match still stands at the tick
      if (sev_pend_r && is_sev && (tb_r == {val_hi_r, val_lo_r})) begin
        tb_nxt = 16'h0000;
      end else begin
        tb_nxt  = tb_r + 16'h0001;
        tb_wrap = (tb_r == 16'hffff);
      end
    end
    if (w_tlo) tb_nxt[7:0] = pwdata_i[7:0];
    if (w_thi) tb_nxt[15:8] = pwdata_i[7:0];
  end

  always_comb begin
    val_lo_nxt = val_lo_r;
    val_hi_nxt = val_hi_r;
    if (w_lo) val_lo_nxt = pwdata_i[7:0];
    // High byte is read-only while it holds the latched duty
    if (w_hi && !is_pwm) val_hi_nxt = pwdata_i[7:0];
    if (cap_ev) {val_hi_nxt, val_lo_nxt} = tb_r;
    if (is_pwm && pt_reload) val_hi_nxt = val_lo_r;
  end

  // ==========================================================
  // Compare: matching on next values lets actions land with the match
  logic match_nxt, cmp_ev;
  assign match_nxt = (tb_nxt == {val_hi_nxt, val_lo_nxt});
  // Frozen in sleep; compare is not promised to work there
  assign cmp_ev    = is_cmp & ~sleep_i & match_nxt & ~match_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_r     <= 16'h0000;
      val_lo_r <= 8'h00;
      val_hi_r <= 8'h00;
      match_r  <= 1'b0;
    end else begin
      tb_r     <= tb_nxt;
      val_lo_r <= val_lo_nxt;
      val_hi_r <= val_hi_nxt;
      match_r  <= match_nxt;
    end
  end

  // ==========================================================
  // Special event trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_r     <= 1'b0;
      adc_r      <= 1'b0;
      sev_pend_r <= 1'b0;
    end else begin
      trig_r <= cmp_ev & is_sev;
      adc_r  <= cmp_ev & is_sev & adc_enable_i;
      if (cmp_ev && is_sev) sev_pend_r <= 1'b1;
      else if (tb_tick || !is_sev) sev_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // Flags: write one to clear, a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_flag_r <= 1'b0;
      ovf_flag_r <= 1'b0;
    end else begin
      if (cap_ev || cmp_ev) evt_flag_r <= 1'b1;
      else if (w_flg && pwdata_i[cpw_pkg::FLAG_EVT_BIT]) evt_flag_r <= 1'b0;
      if (tb_wrap) ovf_flag_r <= 1'b1;
      else if (w_flg && pwdata_i[cpw_pkg::FLAG_OVF_BIT]) ovf_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // Output latch shared by compare and PWM
  always_ff @(posedge clk_i) begin
    if (rst_i) out_r <= 1'b0;
    else if (ctrl_zero) out_r <= 1'b0;
    else if (is_pwm) begin
      if (pt_reload) out_r <= ({val_lo_r, dlb_r} != 10'h000);
      else if (pt_on_r && !sleep_i && (base_nxt == {val_hi_r, lat2_r})) out_r <= 1'b0;
    end else if (cmp_ev) begin
      unique case (mode_r)
        cpw_pkg::MODE_TOGGLE: out_r <= ~out_r;
        cpw_pkg::MODE_SET:    out_r <= 1'b1;
        cpw_pkg::MODE_CLR:    out_r <= 1'b0;
        default:              out_r <= out_r;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) lat2_r <= 2'h0;
    else if (is_pwm && pt_reload) lat2_r <= dlb_r;
  end

  // Pin driven only in toggle, set, clear and PWM modes
  always_ff @(posedge clk_i) begin
    if (rst_i) oe_n_r <= 1'b1;
    else oe_n_r <= ~(is_pwm | (mode_r == cpw_pkg::MODE_TOGGLE) |
                     (mode_r == cpw_pkg::MODE_SET) | (mode_r == cpw_pkg::MODE_CLR));
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r   <= cpw_pkg::MODE_OFF;
      dlb_r    <= 2'h0;
      tb_on_r  <= 1'b0;
      tb_ext_r <= 1'b0;
      period_r <= cpw_pkg::RST_PERIOD;
      pt_on_r  <= 1'b0;
      pt_ps_r  <= 2'h0;
    end else begin
      if (w_ctrl) begin
        mode_r <= pwdata_i[3:0];
        dlb_r  <= pwdata_i[cpw_pkg::CTRL_DUTY_LSB +: 2];
      end
      if (w_tctl) begin
        tb_on_r  <= pwdata_i[cpw_pkg::TB_ON_BIT];
        tb_ext_r <= pwdata_i[cpw_pkg::TB_EXT_BIT];
      end
      if (w_per) period_r <= pwdata_i[7:0];
      if (w_pctl) begin
        pt_on_r <= pwdata_i[cpw_pkg::PT_ON_BIT];
        pt_ps_r <= pwdata_i[cpw_pkg::PT_PS_LSB +: 2];
      end
    end
  end

  // ==========================================================
  // Read mux and APB answer
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr_i)
      cpw_pkg::ADDR_CTRL:    rd_mux[5:0] = {dlb_r, mode_r};
      cpw_pkg::ADDR_VAL_LO:  rd_mux[7:0] = val_lo_r;
      cpw_pkg::ADDR_VAL_HI:  rd_mux[7:0] = val_hi_r;
      cpw_pkg::ADDR_TB_LO:   rd_mux[7:0] = tb_r[7:0];
      cpw_pkg::ADDR_TB_HI:   rd_mux[7:0] = tb_r[15:8];
      cpw_pkg::ADDR_TB_CTRL: rd_mux[1:0] = {tb_ext_r, tb_on_r};
      cpw_pkg::ADDR_PERIOD:  rd_mux[7:0] = period_r;
      cpw_pkg::ADDR_PT_CTRL: rd_mux[2:0] = {pt_on_r, pt_ps_r};
      cpw_pkg::ADDR_PT_CNT:  rd_mux[7:0] = pt_r;
      cpw_pkg::ADDR_FLAGS:   rd_mux[1:0] = {ovf_flag_r, evt_flag_r};
      default:               rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel_i & penable_i & ~pready_r;
      pslverr_r <= psel_i & penable_i & ~pready_r & ~rd_hit;
      if (psel_i && penable_i && !pready_r && !pwrite_i) prdata_r <= rd_mux;
    end
  end

  assign prdata_o    = prdata_r;
  assign pready_o    = pready_r;
  assign pslverr_o   = pslverr_r;
  assign pin_o       = out_r;
  assign pin_oe_n_o  = oe_n_r;
  assign trigger_o   = trig_r;
  assign adc_start_o = adc_r;
endmodule : cpw_channel

//--- sim/cpw_channel_properties.sv
// Port checker for the capture/compare/PWM channel.
// Assumes one clock domain: clk_i with synchronous active-high rst_i.
`timescale 1ns/1ps
module cpw_channel_properties (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // APB slave
  input wire logic [7:0]  paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Pin and special event
  input wire logic        pin_o,
  input wire logic        pin_oe_n_o,
  input wire logic        trigger_o,
  input wire logic        adc_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Sequences
  sequence s_wait;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_ctrl_zero;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == cpw_pkg::ADDR_CTRL && pwdata_i[5:0] == 6'h00;
  endsequence
  // ==========================================================
  // Properties
  AST_RESET_IDLE: assert property ($fell(rst_i) |-> pin_oe_n_o && !pin_o && !trigger_o && !adc_start_o)
    else $error("outputs not idle after reset");
  AST_ONE_WAIT: assert property (s_wait |=> pready_o)
    else $error("no answer one cycle after access");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  AST_TRIG_PULSE: assert property (trigger_o |=> !trigger_o)
    else $error("trigger longer than one cycle");
  AST_ADC_FROM_TRIG: assert property (adc_start_o |-> trigger_o)
    else $error("conversion start without trigger");
  AST_TRIG_PIN_FREE: assert property (trigger_o |-> pin_oe_n_o)
    else $error("pin driven in trigger mode");
  AST_CLEAR_RELEASE: assert property (s_ctrl_zero |-> ##[2:3] (pin_oe_n_o && !pin_o))
    else $error("zero control write left pin driven");
endmodule : cpw_channel_properties

bind cpw_channel cpw_channel_properties cpw_channel_properties_inst (
  .clk_i, .rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .pready_o,
  .pslverr_o, .pin_o, .pin_oe_n_o, .trigger_o, .adc_start_o);

//--- sim/cpw_pin_model.sv
// Outside circuit on the channel pin and the external time base source.
// Assumes the bench sets the level driven while the channel lets go.
`timescale 1ns/1ps
module cpw_pin_model (
  // From bench and channel
  input  wire logic level_i,
  input  wire logic run_i,
  input  wire logic drv_i,
  input  wire logic drv_oe_n_i,
  // To channel
  output logic      pin_o,
  output logic      ext_clk_o
);
  logic osc_r = 1'b0;
  // Pin reads back the channel's drive once the channel owns it
  assign pin_o = drv_oe_n_i ? level_i : drv_i;
  // Slow source, its edges always on falling edges of the system clock
  always #1000 osc_r = run_i ? !osc_r : 1'b0;
  assign ext_clk_o = osc_r;
endmodule : cpw_pin_model

//--- sim/tb_top.sv
// Self-checking bench for the capture/compare/PWM channel.
// Assumes the channel, its package, the checker and the pin model.
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  paddr_i = 8'h00;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic        sleep_i = 1'b0;
  logic        adc_enable_i = 1'b0;
  logic        lvl = 1'b0;
  logic        run = 1'b0;
  logic [31:0] prdata_o, rd, cap;
  logic        pready_o, pslverr_o, pin_i, pin_o, pin_oe_n_o, trigger_o, adc_start_o, tb_ext_clk_i, err;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #20 clk_i = !clk_i;
  cpw_channel cpw_channel_inst (.clk_i, .rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .sleep_i, .adc_enable_i, .tb_ext_clk_i, .pin_i, .pin_o,
    .pin_oe_n_o, .trigger_o, .adc_start_o);
  cpw_pin_model cpw_pin_model_inst (.level_i(lvl), .run_i(run), .drv_i(pin_o), .drv_oe_n_i(pin_oe_n_o),
    .pin_o(pin_i), .ext_clk_o(tb_ext_clk_i));
  // ==========================================================
  // Shared tasks
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdk(input logic [7:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rd, e);
  endtask : rdk
  task automatic pulse;
    lvl <= 1'b1;
    repeat (8) @(posedge clk_i);
    lvl <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : pulse
  task automatic wait_trig;
    int n;
    n = 0;
    do begin @(negedge clk_i); n++; end while (trigger_o !== 1'b1 && n < 600);
  endtask : wait_trig
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdk(cpw_pkg::ADDR_PERIOD, 32'hff, "period reset");
    rdk(cpw_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask : t_regs
  task automatic t_cmp(input logic [3:0] m, input logic p, input logic oe, input logic clr);
    if (clr)
      wr(cpw_pkg::ADDR_CTRL, 32'h0);
    wr(cpw_pkg::ADDR_VAL_LO, 32'h10);
    wr(cpw_pkg::ADDR_VAL_HI, 32'h0);
    wr(cpw_pkg::ADDR_TB_HI, 32'h0);
    wr(cpw_pkg::ADDR_TB_LO, 32'h0);
    wr(cpw_pkg::ADDR_FLAGS, 32'h3);
    wr(cpw_pkg::ADDR_CTRL, {28'h0, m});
    repeat (60) begin
      apb(1'b0, cpw_pkg::ADDR_FLAGS, 32'h0);
      if (rd[0] === 1'b1)
        break;
    end
    chk("event flag", rd, 32'h1);
    @(negedge clk_i);
    chk("pin after match", {30'h0, pin_oe_n_o, pin_o}, {30'h0, oe, p});
  endtask : t_cmp
  task automatic t_sev;
    adc_enable_i <= 1'b1;
    t_cmp(cpw_pkg::MODE_SEV, 1'b0, 1'b1, 1'b1);
    wait_trig;
    chk("trigger and start", {30'h0, trigger_o, adc_start_o}, 32'h3);
    // Clear lands on the next instruction tick, at most four cycles on
    repeat (2) @(posedge clk_i);
    rdk(cpw_pkg::ADDR_TB_LO, 32'h0, "count cleared");
    rdk(cpw_pkg::ADDR_FLAGS, 32'h1, "no overflow");
    // Match at the top count: the clear must not look like a wrap
    wr(cpw_pkg::ADDR_VAL_LO, 32'hff);
    wr(cpw_pkg::ADDR_VAL_HI, 32'hff);
    wr(cpw_pkg::ADDR_TB_HI, 32'hff);
    wr(cpw_pkg::ADDR_TB_LO, 32'hf0);
    wr(cpw_pkg::ADDR_FLAGS, 32'h3);
    wait_trig;
    repeat (8) @(posedge clk_i);
    rdk(cpw_pkg::ADDR_TB_HI, 32'h0, "reset at top");
    rdk(cpw_pkg::ADDR_FLAGS, 32'h1, "no overflow at top");
    wr(cpw_pkg::ADDR_CTRL, 32'h0);
  endtask : t_sev
  task automatic t_cap(input logic [3:0] m, input int n);
    wr(cpw_pkg::ADDR_CTRL, {28'h0, m});
    repeat (2) pulse;
    wr(cpw_pkg::ADDR_CTRL, 32'h0);
    wr(cpw_pkg::ADDR_FLAGS, 32'h3);
    wr(cpw_pkg::ADDR_CTRL, {28'h0, m});
    repeat (n - 1) pulse;
    rdk(cpw_pkg::ADDR_FLAGS, 32'h0, "early capture");
    pulse;
    rdk(cpw_pkg::ADDR_FLAGS, 32'h1, "capture");
  endtask : t_cap
  task automatic t_hold;
    logic [7:0] a;
    wr(cpw_pkg::ADDR_TB_CTRL, 32'h1);
    sleep_i <= 1'b1;
    apb(1'b0, cpw_pkg::ADDR_TB_LO, 32'h0);
    a = rd[7:0];
    repeat (40) @(posedge clk_i);
    rdk(cpw_pkg::ADDR_TB_LO, {24'h0, a}, "held in sleep");
    sleep_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    apb(1'b0, cpw_pkg::ADDR_TB_LO, 32'h0);
    a = rd[7:0] - a;
    chk("resumed", {31'h0, a >= 8'd10 && a <= 8'd12}, 32'h1);
  endtask : t_hold
  task automatic t_ext;
    wr(cpw_pkg::ADDR_TB_CTRL, 32'h3);
    wr(cpw_pkg::ADDR_VAL_HI, 32'h0);
    wr(cpw_pkg::ADDR_TB_HI, 32'h0);
    wr(cpw_pkg::ADDR_VAL_LO, 32'h4);
    wr(cpw_pkg::ADDR_TB_LO, 32'h0);
    wr(cpw_pkg::ADDR_CTRL, {28'h0, cpw_pkg::MODE_SEV});
    wait_trig;
    wr(cpw_pkg::ADDR_VAL_LO, 32'h50);
    repeat (60) @(posedge clk_i);
    rdk(cpw_pkg::ADDR_TB_LO, 32'h5, "reset cancelled");
    sleep_i <= 1'b1;
    t_cap(cpw_pkg::MODE_CAP_RISE, 1);
    apb(1'b0, cpw_pkg::ADDR_VAL_LO, 32'h0);
    cap = rd;
    apb(1'b0, cpw_pkg::ADDR_TB_LO, 32'h0);
    chk("captured count", {31'h0, rd - cap < 32'h2}, 32'h1);
    sleep_i <= 1'b0;
  endtask : t_ext
  task automatic t_pwm(input logic [9:0] d, input int hi);
    int c;
    wr(cpw_pkg::ADDR_PERIOD, 32'h3);
    wr(cpw_pkg::ADDR_PT_CTRL, 32'h4);
    wr(cpw_pkg::ADDR_VAL_LO, {24'h0, d[9:2]});
    wr(cpw_pkg::ADDR_CTRL, {26'h0, d[1:0], 4'hc});
    repeat (40) @(posedge clk_i);
    c = 0;
    repeat (32) begin @(negedge clk_i); c += pin_o; end
    chk("pwm high cycles", 32'(c), 32'(hi));
    chk("pwm drives", {31'h0, pin_oe_n_o}, 32'h0);
  endtask : t_pwm
  // ==========================================================
  // Hang guard and main sequence
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("idle pin", {30'h0, pin_oe_n_o, pin_o}, 32'h2);
    t_regs;
    wr(cpw_pkg::ADDR_TB_CTRL, 32'h1);
    t_cmp(cpw_pkg::MODE_SET, 1'b1, 1'b0, 1'b1);
    t_cmp(cpw_pkg::MODE_CLR, 1'b0, 1'b0, 1'b0);
    t_cmp(cpw_pkg::MODE_TOGGLE, 1'b1, 1'b0, 1'b1);
    t_cmp(cpw_pkg::MODE_SWINT, 1'b0, 1'b1, 1'b1);
    t_sev;
    t_cap(cpw_pkg::MODE_CAP_FALL, 1);
    t_cap(cpw_pkg::MODE_CAP_RISE, 1);
    t_cap(cpw_pkg::MODE_CAP_4, 4);
    t_cap(cpw_pkg::MODE_CAP_16, 16);
    t_hold;
    run <= 1'b1;
    t_ext;
    run <= 1'b0;
    t_pwm(10'h006, 12);
    t_pwm(10'h000, 0);
    wr(cpw_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge clk_i);
    chk("pwm released", {31'h0, pin_oe_n_o}, 32'h1);
    conclude;
  end
endmodule : tb_top
